// ### hdl/result_mem.sv
// Small result memory: one word per channel, registered read data.
// Assumes writer and reader share mclk; reads see a write one cycle later.
`timescale 1ns/100ps
module result_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic mclk, // Clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write address
  input wire logic [WIDTH-1:0] wr_data, // Write data
  input wire logic [AW-1:0] rd_addr, // Read address
  output logic [WIDTH-1:0] rd_data // Registered read data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule : result_mem

// ### hdl/sensor_conv_core.sv
// Conversion sequencer, limit checker and status registers of a 3-axis magnetic sensor.
// Assumes a byte register port from the serial framing logic and an analog front end
// that delivers adc_data when each ADC conversion finishes.
`timescale 1ns/100ps
module sensor_conv_core #(
  parameter int SPIN_CYCLES = 16,
  parameter int ADC_CYCLES = 12,
  parameter int IRQ_PULSE = sensor_conv_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic reg_wr, // Register write strobe
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_rd, // Register read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic bus_trigger, // Trigger command pulse from the bus
  input wire sensor_conv_pkg::conv_cfg_s cfg, // Conversion and limit configuration
  input wire sensor_conv_pkg::fault_evt_s fault_evt, // Fault detector pulses
  input wire logic irq_pin_in, // Interrupt pin level, asynchronous
  output logic irq_pin_out, // Interrupt pin drive value, always low
  output logic irq_pin_oe, // Interrupt pin drive enable
  output logic spin_start, // Pulse: spin stage begins a sample
  output sensor_conv_pkg::axis_t spin_axis, // Axis being spun
  output logic adc_start, // Pulse: ADC stage begins a sample
  output sensor_conv_pkg::axis_t adc_axis, // Axis being digitised
  input wire logic signed [15:0] adc_data, // ADC result, sampled at ADC end
  output logic conv_busy, // A conversion set is running
  input wire sensor_conv_pkg::axis_t result_rd_addr, // Result read channel
  output logic [15:0] result_rd_data // Result, compensated on magnetic axes and raw for temperature, registered
);

  // Number of samples in a set, temperature included
  function automatic logic [2:0] seq_len(input logic [3:0] ch);
    case (ch)
      4'h1, 4'h2, 4'h4: seq_len = 3'h2;
      4'h3, 4'h5, 4'h6: seq_len = 3'h3;
      4'h7, sensor_conv_pkg::CH_XYX, sensor_conv_pkg::CH_YXY,
      sensor_conv_pkg::CH_YZY, sensor_conv_pkg::CH_XZX: seq_len = 3'h4;
      default: seq_len = 3'h1;
    endcase
  endfunction : seq_len

  // Axis of sample idx; sample 0 is always temperature
  function automatic sensor_conv_pkg::axis_t seq_axis(input logic [3:0] ch, input logic [1:0] idx);
    logic [5:0] order;
    order = '0;
    case (ch)
      4'h1: order = {sensor_conv_pkg::AXIS_X, 4'h0};
      4'h2: order = {sensor_conv_pkg::AXIS_Y, 4'h0};
      4'h3: order = {sensor_conv_pkg::AXIS_X, sensor_conv_pkg::AXIS_Y, 2'h0};
      4'h4: order = {sensor_conv_pkg::AXIS_Z, 4'h0};
      4'h5: order = {sensor_conv_pkg::AXIS_Z, sensor_conv_pkg::AXIS_X, 2'h0};
      4'h6: order = {sensor_conv_pkg::AXIS_Y, sensor_conv_pkg::AXIS_Z, 2'h0};
      4'h7: order = {sensor_conv_pkg::AXIS_X, sensor_conv_pkg::AXIS_Y, sensor_conv_pkg::AXIS_Z};
      sensor_conv_pkg::CH_XYX: order = {sensor_conv_pkg::AXIS_X, sensor_conv_pkg::AXIS_Y,
                                        sensor_conv_pkg::AXIS_X};
      sensor_conv_pkg::CH_YXY: order = {sensor_conv_pkg::AXIS_Y, sensor_conv_pkg::AXIS_X,
                                        sensor_conv_pkg::AXIS_Y};
      sensor_conv_pkg::CH_YZY: order = {sensor_conv_pkg::AXIS_Y, sensor_conv_pkg::AXIS_Z,
                                        sensor_conv_pkg::AXIS_Y};
      sensor_conv_pkg::CH_XZX: order = {sensor_conv_pkg::AXIS_X, sensor_conv_pkg::AXIS_Z,
                                        sensor_conv_pkg::AXIS_X};
      default: order = '0;
    endcase
    case (idx)
      2'h0: seq_axis = sensor_conv_pkg::AXIS_T;
      2'h1: seq_axis = order[5:4];
      2'h2: seq_axis = order[3:2];
      default: seq_axis = order[1:0];
    endcase
  endfunction : seq_axis

  // Magnet drift correction: raw * (1 + gain * dt / 2^TC_SHIFT)
  function automatic logic signed [15:0] temp_comp(input logic signed [15:0] raw,
                                                   input logic signed [15:0] dt,
                                                   input logic [1:0] tc);
    logic signed [40:0] prod;
    logic [8:0] gain;
    gain = sensor_conv_pkg::TC_GAIN_0;
    case (tc)
      2'h1: gain = sensor_conv_pkg::TC_GAIN_1;
      2'h2: gain = sensor_conv_pkg::TC_GAIN_2;
      2'h3: gain = sensor_conv_pkg::TC_GAIN_3;
      default: gain = sensor_conv_pkg::TC_GAIN_0;
    endcase
    prod = 41'(raw) * 41'(dt) * $signed({32'h0, gain});
    temp_comp = raw + 16'(prod >>> sensor_conv_pkg::TC_SHIFT);
  endfunction : temp_comp

  logic pin_s1_r, pin_s2_r, pin_s3_r;
  logic irq_level_r;
  logic irq_level_d_r;
  logic [3:0] fault_r;
  logic por_r;
  logic result_ready_r;
  logic [2:0] set_count_r;
  sensor_conv_pkg::spin_state_e spin_st_r;
  sensor_conv_pkg::adc_state_e adc_st_r;
  logic [1:0] spin_idx_r;
  logic [2:0] seq_len_r;
  logic [3:0] ch_r;
  logic [20:0] spin_cnt_r;
  logic [15:0] adc_cnt_r;
  logic [1:0] adc_idx_r;
  logic signed [15:0] temp_raw_r;
  logic limit_hit_r;
  logic [31:0] irq_cnt_r;
  logic [7:0] pin_chk_r;
  logic start_set;
  logic spin_done;
  logic adc_done;
  logic hand_off;
  logic last_adc;
  logic trigger;
  logic in_region;
  logic signed [15:0] comp_val;
  logic pin_fault_int;
  logic wr_dev;
  logic wr_conv;
  logic [20:0] spin_len;

  // Pin synchroniser; runs through reset so the level is known at release
  always_ff @(posedge mclk) begin
    pin_s1_r <= irq_pin_in;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_level_r <= pin_s3_r;
    end else if (pin_s2_r == pin_s3_r) begin
      irq_level_r <= pin_s3_r;
    end
  end

  always_ff @(posedge mclk) begin
    irq_level_d_r <= irq_level_r;
  end

  // Host pulling the pin low while the device does not drive it is a trigger
  assign trigger = bus_trigger
                   | (irq_level_d_r & ~irq_level_r & ~irq_pin_oe & (pin_chk_r == 8'h00));

  assign wr_dev = reg_wr & (reg_addr == sensor_conv_pkg::DEVICE_FAULT_STATUS_ADDR);
  assign wr_conv = reg_wr & (reg_addr == sensor_conv_pkg::CONV_STATUS_ADDR);

  // Pin stuck high while the device drives it low
  assign pin_fault_int = irq_pin_oe & irq_level_r
                         & (pin_chk_r >= 8'(sensor_conv_pkg::PIN_SETTLE_CYCLES));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_r <= 4'h0;
    end else begin
      // Set terms are ORed after the clear, so a fault in the clear cycle stays
      fault_r[sensor_conv_pkg::OSC_FAULT_BIT] <=
        (fault_r[sensor_conv_pkg::OSC_FAULT_BIT]
         & ~(wr_dev & reg_wdata[sensor_conv_pkg::OSC_FAULT_BIT]))
        | fault_evt.oscillator_fault;
      fault_r[sensor_conv_pkg::IRQ_PIN_FAULT_BIT] <=
        (fault_r[sensor_conv_pkg::IRQ_PIN_FAULT_BIT]
         & ~(wr_dev & reg_wdata[sensor_conv_pkg::IRQ_PIN_FAULT_BIT]))
        | fault_evt.irq_pin_fault | pin_fault_int;
      fault_r[sensor_conv_pkg::OTP_CRC_FAULT_BIT] <=
        (fault_r[sensor_conv_pkg::OTP_CRC_FAULT_BIT]
         & ~(wr_dev & reg_wdata[sensor_conv_pkg::OTP_CRC_FAULT_BIT]))
        | fault_evt.otp_memory_crc_fault;
      fault_r[sensor_conv_pkg::UV_FAULT_BIT] <=
        (fault_r[sensor_conv_pkg::UV_FAULT_BIT]
         & ~(wr_dev & reg_wdata[sensor_conv_pkg::UV_FAULT_BIT]))
        | fault_evt.supply_undervoltage_fault;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      por_r <= sensor_conv_pkg::POR_RESET;
    end else if (wr_conv & reg_wdata[sensor_conv_pkg::POR_BIT]) begin
      por_r <= 1'b0;
    end
  end

  // Register read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_addr == sensor_conv_pkg::DEVICE_FAULT_STATUS_ADDR) begin
        reg_rdata[sensor_conv_pkg::IRQ_READBACK_BIT] <= irq_level_r;
        reg_rdata[3:0] <= fault_r;
      end else if (reg_addr == sensor_conv_pkg::CONV_STATUS_ADDR) begin
        reg_rdata[sensor_conv_pkg::SET_COUNT_LSB +: 3] <= set_count_r;
        reg_rdata[sensor_conv_pkg::POR_BIT] <= por_r;
        reg_rdata[sensor_conv_pkg::DIAG_BIT] <= |fault_r;
        reg_rdata[sensor_conv_pkg::RESULT_READY_BIT] <= result_ready_r;
      end
    end
  end

  // Set sequencing
  assign start_set = (spin_st_r == sensor_conv_pkg::SP_IDLE)
                     & (adc_st_r == sensor_conv_pkg::AD_IDLE) & ~conv_busy
                     & ((cfg.operating_mode == sensor_conv_pkg::MODE_CONTINUOUS)
                        | ((cfg.operating_mode == sensor_conv_pkg::MODE_TRIGGERED)
                           & trigger));

  // Averaging lengthens the spin-and-integrate time
  assign spin_len = (cfg.conversion_averaging > 3'(sensor_conv_pkg::MAX_AVG_SHIFT))
                    ? 21'(SPIN_CYCLES) << sensor_conv_pkg::MAX_AVG_SHIFT
                    : 21'(SPIN_CYCLES) << cfg.conversion_averaging;
  assign spin_done = (spin_st_r == sensor_conv_pkg::SP_BUSY) & (spin_cnt_r == 21'h1);
  assign adc_done = (adc_st_r == sensor_conv_pkg::AD_BUSY) & (adc_cnt_r == 16'h1);
  assign hand_off = (spin_st_r == sensor_conv_pkg::SP_HOLD)
                    & ((adc_st_r == sensor_conv_pkg::AD_IDLE) | adc_done);
  assign last_adc = adc_done & ({1'b0, adc_idx_r} == seq_len_r - 3'h1);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      conv_busy <= 1'b0;
      ch_r <= 4'h0;
      seq_len_r <= 3'h1;
    end else if (start_set) begin
      conv_busy <= 1'b1;
      ch_r <= cfg.axis_channel_enable;
      seq_len_r <= seq_len(cfg.axis_channel_enable);
    end else if (last_adc) begin
      conv_busy <= 1'b0;
    end
  end

  // Spin stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      spin_st_r <= sensor_conv_pkg::SP_IDLE;
      spin_idx_r <= 2'h0;
      spin_cnt_r <= 21'h0;
      spin_start <= 1'b0;
      spin_axis <= sensor_conv_pkg::AXIS_T;
    end else begin
      spin_start <= 1'b0;
      case (spin_st_r)
        sensor_conv_pkg::SP_IDLE: begin
          if (start_set) begin
            spin_st_r <= sensor_conv_pkg::SP_BUSY;
            spin_idx_r <= 2'h0;
            spin_cnt_r <= spin_len;
            spin_start <= 1'b1;
            spin_axis <= sensor_conv_pkg::AXIS_T;
          end
        end
        sensor_conv_pkg::SP_BUSY: begin
          spin_cnt_r <= spin_cnt_r - 21'h1;
          if (spin_done) begin
            spin_st_r <= sensor_conv_pkg::SP_HOLD;
          end
        end
        sensor_conv_pkg::SP_HOLD: begin
          if (hand_off) begin
            // Next sample spins while the ADC works on this one
            if ({1'b0, spin_idx_r} == seq_len_r - 3'h1) begin
              spin_st_r <= sensor_conv_pkg::SP_IDLE;
            end else begin
              spin_st_r <= sensor_conv_pkg::SP_BUSY;
              spin_idx_r <= spin_idx_r + 2'h1;
              spin_cnt_r <= spin_len;
              spin_start <= 1'b1;
              spin_axis <= seq_axis(ch_r, spin_idx_r + 2'h1);
            end
          end
        end
        default: spin_st_r <= sensor_conv_pkg::SP_IDLE;
      endcase
    end
  end

  // ADC stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      adc_st_r <= sensor_conv_pkg::AD_IDLE;
      adc_cnt_r <= 16'h0;
      adc_idx_r <= 2'h0;
      adc_start <= 1'b0;
      adc_axis <= sensor_conv_pkg::AXIS_T;
    end else begin
      adc_start <= 1'b0;
      case (adc_st_r)
        sensor_conv_pkg::AD_IDLE: begin
          if (hand_off) begin
            adc_st_r <= sensor_conv_pkg::AD_BUSY;
            adc_cnt_r <= 16'(ADC_CYCLES);
            adc_idx_r <= spin_idx_r;
            adc_start <= 1'b1;
            adc_axis <= spin_axis;
          end
        end
        sensor_conv_pkg::AD_BUSY: begin
          adc_cnt_r <= adc_cnt_r - 16'h1;
          if (adc_done) begin
            if (hand_off) begin
              adc_cnt_r <= 16'(ADC_CYCLES);
              adc_idx_r <= spin_idx_r;
              adc_start <= 1'b1;
              adc_axis <= spin_axis;
            end else begin
              adc_st_r <= sensor_conv_pkg::AD_IDLE;
            end
          end
        end
        default: adc_st_r <= sensor_conv_pkg::AD_IDLE;
      endcase
    end
  end

  // Temperature is captured first in every set and corrects later samples
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      temp_raw_r <= sensor_conv_pkg::TEMP_REF;
    end else if (adc_done & (adc_axis == sensor_conv_pkg::AXIS_T)) begin
      temp_raw_r <= adc_data;
    end
  end

  assign comp_val = (adc_axis == sensor_conv_pkg::AXIS_T) ? adc_data
                    : temp_comp(adc_data, temp_raw_r - sensor_conv_pkg::TEMP_REF,
                                cfg.magnet_temp_coefficient);

  result_mem #(
    .WIDTH(16),
    .DEPTH(4),
    .AW(2)
  ) u_result_mem (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(adc_done),
    .wr_addr(adc_axis),
    .wr_data(comp_val),
    .rd_addr(result_rd_addr),
    .rd_data(result_rd_data)
  );

  // Limit check on each enabled magnetic axis
  always_comb begin
    in_region = 1'b0;
    if (cfg.limit_hysteresis_select == sensor_conv_pkg::HYST_BAND) begin
      if (cfg.limit_direction_select == sensor_conv_pkg::DIR_OUT_OF_BAND) begin
        in_region = (comp_val > cfg.limit_thr_hi) | (comp_val < cfg.limit_thr_lo);
      end else begin
        in_region = (comp_val <= cfg.limit_thr_hi) & (comp_val >= cfg.limit_thr_lo);
      end
    end else if (cfg.limit_direction_select == sensor_conv_pkg::DIR_OUT_OF_BAND) begin
      in_region = comp_val > cfg.limit_thr_hi;
    end else begin
      in_region = comp_val < cfg.limit_thr_lo;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      limit_hit_r <= 1'b0;
    end else if (start_set) begin
      limit_hit_r <= 1'b0;
    end else if (adc_done & (adc_axis != sensor_conv_pkg::AXIS_T)
                 & cfg.limit_axis_enable[adc_axis - 2'h1] & in_region) begin
      limit_hit_r <= 1'b1;
    end
  end

  // Interrupt pulse after every set that ends with a hit, not only the first
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_pin_oe <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_cnt_r <= 32'h0;
    end else if (last_adc & (limit_hit_r
                 | (cfg.limit_axis_enable[adc_axis - 2'h1] & in_region
                    & (adc_axis != sensor_conv_pkg::AXIS_T)))) begin
      irq_pin_oe <= 1'b1;
      irq_cnt_r <= 32'(IRQ_PULSE);
    end else if (irq_cnt_r > 32'h1) begin
      irq_cnt_r <= irq_cnt_r - 32'h1;
    end else begin
      irq_pin_oe <= 1'b0;
      irq_cnt_r <= 32'h0;
    end
  end

  // Counts up while driven, down to 0 from at most PIN_SETTLE_CYCLES after release; masks sync latency for trigger and fault checks
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_chk_r <= 8'h00;
    end else if (irq_pin_oe) begin
      pin_chk_r <= (pin_chk_r == 8'hFF) ? pin_chk_r : pin_chk_r + 8'h01;
    end else if (pin_chk_r != 8'h00) begin
      pin_chk_r <= (pin_chk_r > 8'(sensor_conv_pkg::PIN_SETTLE_CYCLES))
                   ? 8'(sensor_conv_pkg::PIN_SETTLE_CYCLES) : pin_chk_r - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      result_ready_r <= 1'b0;
      set_count_r <= 3'h0;
    end else if (last_adc) begin
      result_ready_r <= 1'b1;
      set_count_r <= set_count_r + 3'h1;
    end else if (start_set) begin
      result_ready_r <= 1'b0;
    end
  end

endmodule : sensor_conv_core

// ### hdl/sensor_conv_pkg.sv
// Shared constants, types and register layout for the sensor conversion block.
// Assumes a single 250 MHz clock and a byte-wide register port from the serial framing logic.
package sensor_conv_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] CONV_STATUS_ADDR = 8'h18;
  localparam logic [7:0] DEVICE_FAULT_STATUS_ADDR = 8'h1C;

  // device_fault_status field positions
  localparam int IRQ_READBACK_BIT = 4;
  localparam int OSC_FAULT_BIT = 3;
  localparam int IRQ_PIN_FAULT_BIT = 2;
  localparam int OTP_CRC_FAULT_BIT = 1;
  localparam int UV_FAULT_BIT = 0;

  // Conversion status field positions and reset values
  localparam int SET_COUNT_LSB = 5;
  localparam int POR_BIT = 4;
  localparam int DIAG_BIT = 1;
  localparam int RESULT_READY_BIT = 0;
  localparam logic POR_RESET = 1'h1;

  // Operating modes
  localparam logic [1:0] MODE_TRIGGERED = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;

  // Limit checker settings
  localparam logic [2:0] HYST_BAND = 3'h1;
  localparam logic DIR_OUT_OF_BAND = 1'h0;

  // Axis codes; also result memory addresses
  typedef logic [1:0] axis_t;
  localparam axis_t AXIS_T = 2'h0;
  localparam axis_t AXIS_X = 2'h1;
  localparam axis_t AXIS_Y = 2'h2;
  localparam axis_t AXIS_Z = 2'h3;

  // Channel enable codes for pseudo-simultaneous orderings
  localparam logic [3:0] CH_XYX = 4'h8;
  localparam logic [3:0] CH_YXY = 4'h9;
  localparam logic [3:0] CH_YZY = 4'hA;
  localparam logic [3:0] CH_XZX = 4'hB;

  // Magnet temperature coefficient gains, scaled by 2^TC_SHIFT per temperature code
  localparam logic [8:0] TC_GAIN_0 = 9'h000;
  localparam logic [8:0] TC_GAIN_1 = 9'h008;
  localparam logic [8:0] TC_GAIN_2 = 9'h00D;
  localparam logic [8:0] TC_GAIN_3 = 9'h010;
  localparam int TC_SHIFT = 16;
  localparam logic signed [15:0] TEMP_REF = 16'sh4000;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int IRQ_PULSE_NS = 10000;
  localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int PIN_SETTLE_NS = 40;
  localparam int PIN_SETTLE_CYCLES = (PIN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MAX_AVG_SHIFT = 5;

  typedef enum logic [1:0] {SP_IDLE, SP_BUSY, SP_HOLD} spin_state_e;
  typedef enum logic {AD_IDLE, AD_BUSY} adc_state_e;

  typedef struct packed {
    logic [1:0] operating_mode;
    logic [3:0] axis_channel_enable;
    logic [2:0] conversion_averaging;
    logic [1:0] magnet_temp_coefficient;
    logic limit_direction_select;
    logic [2:0] limit_hysteresis_select;
    logic [2:0] limit_axis_enable;
    logic signed [15:0] limit_thr_hi;
    logic signed [15:0] limit_thr_lo;
  } conv_cfg_s;

  typedef struct packed {
    logic oscillator_fault;
    logic irq_pin_fault;
    logic otp_memory_crc_fault;
    logic supply_undervoltage_fault;
  } fault_evt_s;

endpackage : sensor_conv_pkg

// ### verif/irq_host_model.sv
// Host side: open-drain interrupt wire with pull-up, and changing ADC samples.
// Assumes the bench asks for host pin pulls through host_pull.
`timescale 1ns/100ps
module irq_host_model (
  input wire logic mclk, // Clock
  input wire logic irq_pin_oe, // Device pulls pin low
  input wire logic host_pull, // Host pulls pin low
  output logic irq_pin_in, // Resolved pin level
  output logic signed [15:0] adc_data // Sample, new each cycle
);
  // Pull-up wins only when nobody pulls low; host pull is a trigger
  assign irq_pin_in = !(irq_pin_oe || host_pull);
  initial adc_data = 16'sh0123;
  always @(posedge mclk) adc_data <= adc_data + 16'sh04D5;
endmodule : irq_host_model

// ### verif/sensor_conv_core_chk.sv
// Checker for sensor_conv_core ports: status flags, triggers, axis order, interrupt pulse.
// Bound into the core; assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module sensor_conv_core_chk #(
  parameter int IRQ_PULSE = sensor_conv_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic mclk, // Clock
  input wire logic rstn, // Reset
  input wire logic [7:0] reg_addr, // Offset
  input wire logic reg_wr, // Write
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic bus_trigger, // Trigger
  input wire sensor_conv_pkg::conv_cfg_s cfg, // Config
  input wire sensor_conv_pkg::fault_evt_s fault_evt, // Faults
  input wire logic irq_pin_in, // Pin level
  input wire logic irq_pin_oe, // Pin drive
  input wire logic spin_start, // Spin pulse
  input wire sensor_conv_pkg::axis_t spin_axis, // Spin axis
  input wire logic adc_start, // ADC pulse
  input wire sensor_conv_pkg::axis_t adc_axis, // ADC axis
  input wire logic conv_busy // Busy
);
  wire rf = reg_rd && !reg_wr && reg_addr == sensor_conv_pkg::DEVICE_FAULT_STATUS_ADDR;
  wire rc = reg_rd && !reg_wr && reg_addr == sensor_conv_pkg::CONV_STATUS_ADDR;
  wire wf = reg_wr && reg_addr == sensor_conv_pkg::DEVICE_FAULT_STATUS_ADDR;
  wire uv = fault_evt.supply_undervoltage_fault;
  int oe_cnt;
  // Length of the current pin pulse
  always_ff @(posedge mclk) oe_cnt <= irq_pin_oe ? oe_cnt + 1 : 0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rsv; rf |=> reg_rdata[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rb; $stable(irq_pin_in)[*6] ##0 rf |=> reg_rdata[4] == $past(irq_pin_in); endproperty
  a_rb: assert property (p_rb) else $error("pin readback wrong");
  property p_osc; fault_evt.oscillator_fault ##1 (fault_evt.oscillator_fault && wf) ##1 !wf ##1 rf
    |=> reg_rdata[3]; endproperty
  a_osc: assert property (p_osc) else $error("osc flag lost");
  property p_otp; rf ##1 (reg_rdata[1] && !wf) ##1 (wf && !reg_wdata[1]) ##1 !wf ##1 rf
    |=> reg_rdata[1]; endproperty
  a_otp: assert property (p_otp) else $error("zero write cleared flag");
  property p_uv; (wf && reg_wdata[0] && !uv) ##1 !uv ##1 (rf && !uv) |=> !reg_rdata[0]; endproperty
  a_uv: assert property (p_uv) else $error("uv flag not cleared");
  property p_diag; rf ##1 (|reg_rdata[3:0] && !wf) ##1 rc |=> reg_rdata[1]; endproperty
  a_diag: assert property (p_diag) else $error("diag bit clear");
  property p_trig; bus_trigger && !conv_busy && cfg.operating_mode == 2'h0
    |-> ##[1:2] spin_start && spin_axis == sensor_conv_pkg::AXIS_T; endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
  property p_xzx; adc_start && adc_axis == 2'h0 && cfg.axis_channel_enable == 4'hB
    |-> spin_start && spin_axis == sensor_conv_pkg::AXIS_X; endproperty
  a_xzx: assert property (p_xzx) else $error("no pipelined spin");
  property p_irq; $fell(irq_pin_oe) |-> oe_cnt == IRQ_PULSE; endproperty
  a_irq: assert property (p_irq) else $error("pin pulse length");
endmodule : sensor_conv_core_chk
bind sensor_conv_core sensor_conv_core_chk #(.IRQ_PULSE(IRQ_PULSE)) u_chk (.*);

// ### verif/test_sensor_conv_core.sv
// Bench for sensor_conv_core: status flags, trigger orders and limit interrupts.
// Assumes irq_host_model resolves the pin and feeds ADC samples.
`timescale 1ns/100ps
module test_sensor_conv_core;
  localparam logic [7:0] FS = sensor_conv_pkg::DEVICE_FAULT_STATUS_ADDR;
  localparam logic [7:0] CS = sensor_conv_pkg::CONV_STATUS_ADDR;
  logic mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, bus_trigger = 1'h0;
  logic host_pull = 1'h0, rd_d = 1'h0, oe_d = 1'h0;
  logic irq_pin_in, irq_pin_out, irq_pin_oe, spin_start, adc_start, conv_busy;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, b;
  logic signed [15:0] adc_data;
  sensor_conv_pkg::conv_cfg_s cfg = '0;
  sensor_conv_pkg::fault_evt_s fault_evt = '0;
  sensor_conv_pkg::axis_t spin_axis, adc_axis, h;
  logic [4:0] sr = 5'h00;
  logic [15:0] xres = 16'h0000, rrd;
  logic [7:0] exq[$], axq[$];
  int error_cnt = 0, cmp_count = 0, n = 0, seed = 32'h8284;
  always #2 mclk = ~mclk;
  sensor_conv_core #(.SPIN_CYCLES(8), .ADC_CYCLES(6), .IRQ_PULSE(8)) uut (
    .result_rd_addr(sensor_conv_pkg::AXIS_X), .result_rd_data(rrd), .*);
  irq_host_model host (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge mclk);
    reg_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'h1;
    exq.push_back(e);
    @(negedge mclk);
    reg_rd = 1'h0;
  endtask : rd
  task automatic waitb(input logic v);
    for (int i = 0; i < 500 && conv_busy !== v; i++) @(negedge mclk);
    chk(8'(conv_busy), 8'(v));
  endtask : waitb
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Results are matched against the oldest note as they appear
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    oe_d <= irq_pin_oe;
    // The ADC samples its input at the edge ADC_CYCLES after adc_start
    sr <= {sr[3:0], adc_start};
    if (sr[4] && adc_axis == sensor_conv_pkg::AXIS_X) xres <= adc_data;
    if (irq_pin_oe && !oe_d) n++;
  end
  always @(negedge mclk) begin
    if (rd_d) chk(reg_rdata, exq.pop_front());
    if (spin_start && axq.size() > 0) chk({6'h00, spin_axis}, axq.pop_front());
    if (irq_pin_oe) chk({7'h00, irq_pin_out}, 8'h00);
  end
  initial begin
    #80000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'h1;
    rd(FS, 8'h10);
    rd(8'h33, 8'h00);
    rd(CS, 8'h10);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      b = 8'(1 << i);
      fault_evt = 4'(b);
      wr(FS, 8'hFF);
      fault_evt = '0;
      rd(FS, 8'h10 | b);
      wr(FS, 8'($random(seed)) & ~b);
      rd(FS, 8'h10 | b);
      rd(CS, 8'h12);
      wr(FS, b);
      rd(FS, 8'h10);
    end
    $display("fault flags done");
    host_pull = 1'h1;
    waitb(1'h1);
    rd(FS, 8'h00);
    host_pull = 1'h0;
    waitb(1'h0);
    rd(FS, 8'h10);
    for (int k = 0; k < 2; k++) begin
      h = k ? sensor_conv_pkg::AXIS_Y : sensor_conv_pkg::AXIS_X;
      cfg.axis_channel_enable = k ? sensor_conv_pkg::CH_YZY : sensor_conv_pkg::CH_XZX;
      axq = {8'h00, 8'(h), 8'h03, 8'(h)};
      bus_trigger = 1'h1;
      @(negedge mclk);
      bus_trigger = 1'h0;
      waitb(1'h1);
      waitb(1'h0);
      chk(8'(axq.size()), 8'h00);
      @(negedge mclk);
      chk(rrd[7:0], xres[7:0]);
      chk(rrd[15:8], xres[15:8]);
    end
    $display("triggers and orders done");
    cfg.axis_channel_enable = 4'h1;
    cfg.limit_axis_enable = 3'h1;
    cfg.limit_thr_lo = 16'sh8000;
    for (int m = 0; m < 3; m++) begin
      cfg.limit_direction_select = (m == 1);
      cfg.limit_hysteresis_select = (m > 0) ? sensor_conv_pkg::HYST_BAND : 3'h0;
      cfg.limit_thr_hi = (m > 0) ? 16'sh7FFF : 16'sh8000;
      n = 0;
      cfg.operating_mode = sensor_conv_pkg::MODE_CONTINUOUS;
      repeat (400) @(negedge mclk);
      cfg.operating_mode = sensor_conv_pkg::MODE_TRIGGERED;
      waitb(1'h0);
      chk(8'(n > 2), 8'(m < 2));
    end
    $display("limit checks done");
    print_verdict();
  end
endmodule : test_sensor_conv_core
